// [src/pif_pkg.sv]
package pif_pkg;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_PREFIX = 4'h5;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
    localparam logic [4:0] TENBIT_PREFIX = 5'h1e;

    // ----------------------------------------------------------------
    // Framing and timing
    // ----------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] STRAP_SETTLE = 3'h5;
    localparam int SYNC_WIDTH = 5;
    localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 5'h1f;

    // ----------------------------------------------------------------
    // Serial state machine
    // ----------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE     = 8'h01,
        ST_ADDR     = 8'h02,
        ST_ADDR_ACK = 8'h04,
        ST_RX       = 8'h08,
        ST_RX_ACK   = 8'h10,
        ST_TX       = 8'h20,
        ST_TX_ACK   = 8'h40,
        ST_IGNORE   = 8'h80
    } pif_state_t;

endpackage : pif_pkg

// [src/pif_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pif_sync (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [pif_pkg::SYNC_WIDTH-1:0] async_in,
    output logic [pif_pkg::SYNC_WIDTH-1:0] level_ff
);
    // ----------------------------------------------------------------
    // Three stages per line; a change counts once stages two and three agree
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < pif_pkg::SYNC_WIDTH; i++) begin : g_line
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    s1_ff <= pif_pkg::SYNC_RESET[i];
                    s2_ff <= pif_pkg::SYNC_RESET[i];
                    s3_ff <= pif_pkg::SYNC_RESET[i];
                    level_ff[i] <= pif_pkg::SYNC_RESET[i];
                end else begin
                    s1_ff <= async_in[i];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff) begin
                        level_ff[i] <= s3_ff;
                    end
                end
            end
        end
    endgenerate
endmodule : pif_sync
`default_nettype wire

// [src/pif_shift.sv]
`timescale 1ns/1ps
`default_nettype none
module pif_shift (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [7:0] load_value,
    input wire logic shift_en,
    input wire logic shift_in,
    output logic [7:0] data_ff
);
    // ----------------------------------------------------------------
    // MSB-first byte shifter, load has priority
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            data_ff <= 8'h00;
        end else if (load) begin
            data_ff <= load_value;
        end else if (shift_en) begin
            data_ff <= {data_ff[6:0], shift_in};
        end
    end
endmodule : pif_shift
`default_nettype wire

// [src/pif_i2c_front.sv]
// Summary of operation
// - Not-acknowledge leaves the data line released high in the ack clock.
// - After any error the master sends START; command state restarts there.
// - General call address acknowledged only while general call enable is set.
// - Address is 0101 plus address pins; match acked, mismatch not acked.
// - Address bits of absent pins read as one; up to eight devices share a bus.
// - Lowest address pin level is captured at reset and used thereafter.
// - First byte after START is seven address bits plus direction bit.
// - START is data falling while clock high; begins a new transfer.
// - Repeated START looks like START, continues after a byte instead of STOP.
// - Collision flagged when a released data line samples low at clock rise while sending read data.
// - STOP, data rising while clock high, ends transfer and resets interface.
// - Device never holds the clock low; read data ready without delay.
// - Transfers off the command format are aborted; START or STOP aborts too.
// - High-speed master code is not acknowledged but enables high-speed mode.
// - High-speed mode holds across repeated STARTs and ends at STOP.
// - As receiver, ack low after address byte and after each received byte.
// - Data sampled at clock rise; changes while clock high are START or STOP.
// - Invalid location and command combination gets not-acknowledge.
// - Only seven-bit addressing; ten-bit sequences are not acknowledged.
`timescale 1ns/1ps
`default_nettype none
module pif_i2c_front #(
    parameter int NUM_ADDR_PINS = 3
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out_ff,
    output logic sda_oe_ff,
    input wire logic addr_pin_lsb,
    input wire logic addr_pin_mid,
    input wire logic addr_pin_msb,
    input wire logic general_call_enable,
    input wire logic nvm_write_busy,
    input wire logic data_ack_ok,
    input wire logic [7:0] tx_byte,
    output logic tx_taken_ff,
    output logic [7:0] rx_byte_ff,
    output logic rx_valid_ff,
    output logic addressed_ff,
    output logic general_call_ff,
    output logic read_ff,
    output logic hs_mode_ff,
    output logic start_seen_ff,
    output logic stop_seen_ff,
    output logic bus_collision_ff
);
    // ----------------------------------------------------------------
    // Pin sampling and bus conditions
    // ----------------------------------------------------------------
    logic [pif_pkg::SYNC_WIDTH-1:0] lv;
    logic scl;
    logic sda;
    logic scl_d_ff;
    logic sda_d_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    pif_sync u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({addr_pin_msb, addr_pin_mid, addr_pin_lsb, scl_in, sda_in}),
        .level_ff(lv)
    );

    assign scl = lv[1];
    assign sda = lv[0];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl;
            sda_d_ff <= sda;
        end
    end

    assign scl_rise = scl & ~scl_d_ff;
    assign scl_fall = ~scl & scl_d_ff;
    assign start_cond = scl & scl_d_ff & sda_d_ff & ~sda;
    assign stop_cond = scl & scl_d_ff & ~sda_d_ff & sda;

    // ----------------------------------------------------------------
    // Address strap capture
    // ----------------------------------------------------------------
    logic [2:0] strap_cnt_ff;
    logic strap_lsb_ff;
    logic addr_mid;
    logic addr_msb;
    logic [6:0] own_addr;

    // Wait for the filter to settle, then hold the pin level for good
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            strap_cnt_ff <= 3'h0;
            strap_lsb_ff <= 1'b1;
        end else if (strap_cnt_ff != pif_pkg::STRAP_SETTLE) begin
            strap_cnt_ff <= strap_cnt_ff + 3'h1;
            strap_lsb_ff <= lv[2];
        end
    end

    assign addr_mid = (NUM_ADDR_PINS >= 2) ? lv[3] : 1'b1;
    assign addr_msb = (NUM_ADDR_PINS >= 3) ? lv[4] : 1'b1;
    assign own_addr = {pif_pkg::ADDR_PREFIX, addr_msb, addr_mid, strap_lsb_ff};

    // ----------------------------------------------------------------
    // Byte shifter and decode
    // ----------------------------------------------------------------
    pif_pkg::pif_state_t state_ff;
    pif_pkg::pif_state_t nxt_state;
    logic [3:0] bit_cnt_ff;
    logic [3:0] nxt_bit_cnt;
    logic [7:0] sh;
    logic byte_end;
    logic sh_load;
    logic sh_shift;
    logic addr_match;
    logic gc_hit;
    logic hs_hit;
    logic ten_hit;
    logic ack_addr;
    logic ack_data;
    logic first_data_ff;
    logic collision;
    logic tx_next_msb;

    assign byte_end = scl_fall && (bit_cnt_ff == pif_pkg::BYTE_BITS);
    assign sh_load = scl_fall && (((state_ff == pif_pkg::ST_ADDR_ACK) && read_ff)
                     || (state_ff == pif_pkg::ST_TX_ACK));
    assign sh_shift = (scl_rise && ((state_ff == pif_pkg::ST_ADDR)
                      || (state_ff == pif_pkg::ST_RX)))
                      || (scl_fall && (state_ff == pif_pkg::ST_TX));

    pif_shift u_shift (
        .sys_clk(sys_clk),
        .reset(reset),
        .load(sh_load),
        .load_value(tx_byte),
        .shift_en(sh_shift),
        .shift_in(sda),
        .data_ff(sh)
    );

    assign addr_match = (sh[7:1] == own_addr);
    assign gc_hit = (sh[7:1] == pif_pkg::GC_ADDR) && !sh[0];
    assign hs_hit = (sh[7:3] == pif_pkg::HS_CODE_PREFIX);
    assign ten_hit = (sh[7:3] == pif_pkg::TENBIT_PREFIX);
    assign ack_addr = (addr_match || (gc_hit && general_call_enable))
                      && !ten_hit && !hs_hit;
    assign ack_data = data_ack_ok && !(nvm_write_busy && first_data_ff);

    // A released line seen low while we send means another driver
    assign collision = scl_rise && (state_ff == pif_pkg::ST_TX) && !sda_oe_ff
                       && !sda && (bit_cnt_ff != pif_pkg::BYTE_BITS);

    // ----------------------------------------------------------------
    // Serial state machine
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        if (stop_cond) begin
            nxt_state = pif_pkg::ST_IDLE;
            nxt_bit_cnt = 4'h0;
        end else if (start_cond) begin
            nxt_state = pif_pkg::ST_ADDR;
            nxt_bit_cnt = 4'h0;
        end else if (collision) begin
            nxt_state = pif_pkg::ST_IDLE;
            nxt_bit_cnt = 4'h0;
        end else begin
            case (state_ff)
                pif_pkg::ST_ADDR, pif_pkg::ST_RX, pif_pkg::ST_TX: begin
                    if (scl_rise) begin
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end
                    if (byte_end) begin
                        if (state_ff == pif_pkg::ST_ADDR) begin
                            nxt_state = ack_addr ? pif_pkg::ST_ADDR_ACK
                                                 : pif_pkg::ST_IGNORE;
                        end else if (state_ff == pif_pkg::ST_RX) begin
                            nxt_state = ack_data ? pif_pkg::ST_RX_ACK
                                                 : pif_pkg::ST_IGNORE;
                        end else begin
                            nxt_state = pif_pkg::ST_TX_ACK;
                        end
                    end
                end
                pif_pkg::ST_ADDR_ACK, pif_pkg::ST_RX_ACK: begin
                    if (scl_fall) begin
                        nxt_bit_cnt = 4'h0;
                        nxt_state = (read_ff && state_ff == pif_pkg::ST_ADDR_ACK)
                                    ? pif_pkg::ST_TX : pif_pkg::ST_RX;
                    end
                end
                pif_pkg::ST_TX_ACK: begin
                    if (scl_rise && sda) begin
                        nxt_state = pif_pkg::ST_IGNORE;
                    end else if (scl_fall) begin
                        nxt_bit_cnt = 4'h0;
                        nxt_state = pif_pkg::ST_TX;
                    end
                end
                pif_pkg::ST_IDLE, pif_pkg::ST_IGNORE: begin
                    nxt_state = state_ff;
                end
                default: begin
                    nxt_state = pif_pkg::ST_IDLE;
                    nxt_bit_cnt = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= pif_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Data line drive; the clock line is input only, never stretched
    // ----------------------------------------------------------------
    assign tx_next_msb = sh_load ? tx_byte[7] : (sh_shift ? sh[6] : sh[7]);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sda_oe_ff <= 1'b0;
            sda_out_ff <= 1'b0;
        end else begin
            sda_out_ff <= 1'b0;
            sda_oe_ff <= (nxt_state == pif_pkg::ST_ADDR_ACK)
                         || (nxt_state == pif_pkg::ST_RX_ACK)
                         || ((nxt_state == pif_pkg::ST_TX)
                             && !tx_next_msb);
        end
    end

    // ----------------------------------------------------------------
    // Transfer status
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addressed_ff <= 1'b0;
            general_call_ff <= 1'b0;
            read_ff <= 1'b0;
            first_data_ff <= 1'b0;
        end else if (stop_cond || start_cond || collision) begin
            addressed_ff <= 1'b0;
            general_call_ff <= 1'b0;
            read_ff <= 1'b0;
            first_data_ff <= 1'b0;
        end else if (byte_end && state_ff == pif_pkg::ST_ADDR) begin
            addressed_ff <= ack_addr;
            general_call_ff <= ack_addr && gc_hit;
            read_ff <= ack_addr && sh[0];
            first_data_ff <= ack_addr;
        end else if (byte_end && state_ff == pif_pkg::ST_RX) begin
            first_data_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hs_mode_ff <= 1'b0;
        end else if (stop_cond) begin
            hs_mode_ff <= 1'b0;
        end else if (byte_end && state_ff == pif_pkg::ST_ADDR && hs_hit) begin
            hs_mode_ff <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_byte_ff <= 8'h00;
            rx_valid_ff <= 1'b0;
        end else begin
            rx_valid_ff <= byte_end && (state_ff == pif_pkg::ST_RX) && !stop_cond
                           && !start_cond;
            if (byte_end && state_ff == pif_pkg::ST_RX) begin
                rx_byte_ff <= sh;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_taken_ff <= 1'b0;
            start_seen_ff <= 1'b0;
            stop_seen_ff <= 1'b0;
            bus_collision_ff <= 1'b0;
        end else begin
            tx_taken_ff <= sh_load && !stop_cond && !start_cond;
            start_seen_ff <= start_cond;
            stop_seen_ff <= stop_cond;
            bus_collision_ff <= collision && !stop_cond && !start_cond;
        end
    end

endmodule : pif_i2c_front
`default_nettype wire

// [verification/pif_i2c_front_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pif_i2c_front_props #(
    parameter int NUM_ADDR_PINS = 3
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sda_out_ff,
    input wire logic sda_oe_ff,
    input wire logic general_call_enable,
    input wire logic data_ack_ok,
    input wire logic tx_taken_ff,
    input wire logic rx_valid_ff,
    input wire logic addressed_ff,
    input wire logic general_call_ff,
    input wire logic read_ff,
    input wire logic hs_mode_ff,
    input wire logic start_seen_ff,
    input wire logic stop_seen_ff,
    input wire logic bus_collision_ff
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_quiet_oe;
        !sda_oe_ff [*8];
    endsequence
    sequence s_idle_soon;
        ##[0:2] !addressed_ff;
    endsequence

    a_drive_low_only: assert property (!sda_out_ff)
        else $error("data output not held low");
    a_hs_no_ack: assert property ($rose(hs_mode_ff) |-> s_quiet_oe)
        else $error("master code acknowledged");
    a_rx_nack: assert property (rx_valid_ff && !data_ack_ok |-> s_quiet_oe)
        else $error("refused byte acknowledged");
    a_stop_idle: assert property (stop_seen_ff |->
        ##[0:2] (!addressed_ff && !hs_mode_ff && !sda_oe_ff))
        else $error("stop left interface busy");
    a_hs_held: assert property ($fell(hs_mode_ff) |-> stop_seen_ff || $past(stop_seen_ff))
        else $error("high speed left without stop");
    a_col_idle: assert property (bus_collision_ff |-> s_idle_soon)
        else $error("collision kept selection");
    a_start_resets: assert property (start_seen_ff |-> s_idle_soon)
        else $error("start kept selection");
    a_addr_ack: assert property ($rose(addressed_ff) |-> ##[0:2] sda_oe_ff)
        else $error("address match without ack");
    a_gc_enable: assert property ($rose(general_call_ff) |-> general_call_enable)
        else $error("general call taken while disabled");
    a_tx_when_read: assert property (tx_taken_ff |-> read_ff && addressed_ff)
        else $error("read data taken without read address");
endmodule : pif_i2c_front_props

bind pif_i2c_front pif_i2c_front_props #(.NUM_ADDR_PINS(NUM_ADDR_PINS)) u_props (
    .sys_clk(sys_clk),
    .reset(reset),
    .sda_out_ff(sda_out_ff),
    .sda_oe_ff(sda_oe_ff),
    .general_call_enable(general_call_enable),
    .data_ack_ok(data_ack_ok),
    .tx_taken_ff(tx_taken_ff),
    .rx_valid_ff(rx_valid_ff),
    .addressed_ff(addressed_ff),
    .general_call_ff(general_call_ff),
    .read_ff(read_ff),
    .hs_mode_ff(hs_mode_ff),
    .start_seen_ff(start_seen_ff),
    .stop_seen_ff(stop_seen_ff),
    .bus_collision_ff(bus_collision_ff)
);
`default_nettype wire

// [verification/pif_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
module pif_bus_master (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt
    // Data falls while clock high; also serves as repeated start
    task automatic start_cond();
        wt(6);
        sda_low = 1'h0;
        wt(2);
        scl = 1'h1;
        wt(8);
        sda_low = 1'h1;
        wt(8);
        scl = 1'h0;
    endtask : start_cond
    // Data rises while clock high
    task automatic stop_cond();
        wt(6);
        sda_low = 1'h1;
        wt(2);
        scl = 1'h1;
        wt(8);
        sda_low = 1'h0;
        wt(8);
    endtask : stop_cond
    // Data changes only while clock low, read at end of high phase
    task automatic bit_io(input logic b, output logic seen);
        wt(6);
        sda_low = !b;
        wt(2);
        scl = 1'h1;
        wt(8);
        seen = sda_line;
        scl = 1'h0;
    endtask : bit_io
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'h1, s);
        ack = !s;
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] b, input logic ack_it, input logic clash);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(!clash, b[i]);
        end
        bit_io(!ack_it, s);
    endtask : recv_byte
endmodule : pif_bus_master
`default_nettype wire

// [verification/tb_pif_i2c_front.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_pif_i2c_front;
    logic sys_clk, reset, scl, m_low, lsb, mid, msb, gce, busy, ack_ok, col_seen, ack;
    logic sda_out, oe, tx_taken, rx_valid, addressed, gc, rd, hs, st, sp, col;
    logic [7:0] tx_byte, rx_byte, b;
    int err_count = 0;
    int n_checks = 0;
    wire sda_line = !(m_low | oe);

    pif_bus_master m (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(m_low));
    pif_i2c_front dut (
        .sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
        .sda_out_ff(sda_out), .sda_oe_ff(oe), .addr_pin_lsb(lsb), .addr_pin_mid(mid),
        .addr_pin_msb(msb), .general_call_enable(gce), .nvm_write_busy(busy),
        .data_ack_ok(ack_ok), .tx_byte(tx_byte), .tx_taken_ff(tx_taken),
        .rx_byte_ff(rx_byte), .rx_valid_ff(rx_valid), .addressed_ff(addressed),
        .general_call_ff(gc), .read_ff(rd), .hs_mode_ff(hs), .start_seen_ff(st),
        .stop_seen_ff(sp), .bus_collision_ff(col)
    );

    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (col) col_seen <= 1'h1;

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic addr(input logic [7:0] a);
        m.start_cond();
        m.send_byte(a, ack);
    endtask : addr

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Lowest pin was 0 at reset and is 1 now; only 0101_010 matches
    task automatic t_addr_sweep();
        for (int i = 0; i < 8; i++) begin
            addr({4'h5, 3'(i), 1'h0});
            chk("addr_ack", 8'(ack), 8'(i == 2));
            m.stop_cond();
        end
    endtask : t_addr_sweep
    task automatic t_write();
        addr(8'h54);
        chk("selected", 8'(addressed), 8'h01);
        chk("wr_dir", 8'(rd), 8'h00);
        m.send_byte(8'h96, ack);
        chk("data_ack", 8'(ack), 8'h01);
        chk("rx_byte", rx_byte, 8'h96);
        m.stop_cond();
        chk("stop_sel", 8'(addressed), 8'h00);
    endtask : t_write
    task automatic t_data_nack();
        ack_ok = 1'h0;
        addr(8'h54);
        m.send_byte(8'h11, ack);
        chk("bad_cmd", 8'(ack), 8'h00);
        m.send_byte(8'h22, ack);
        chk("ignored", 8'(ack), 8'h00);
        ack_ok = 1'h1;
        addr(8'h54);
        chk("restart", 8'(ack), 8'h01);
        m.stop_cond();
    endtask : t_data_nack
    task automatic t_busy();
        busy = 1'h1;
        addr(8'h54);
        m.send_byte(8'h33, ack);
        chk("busy_nack", 8'(ack), 8'h00);
        m.stop_cond();
        busy = 1'h0;
    endtask : t_busy
    task automatic t_gcall();
        for (int e = 0; e < 2; e++) begin
            gce = 1'(e);
            addr(8'h00);
            chk("gc_ack", 8'(ack), 8'(e));
            chk("gc_flag", 8'(gc), 8'(e));
            m.stop_cond();
        end
        gce = 1'h0;
    endtask : t_gcall
    task automatic t_hs_tenbit();
        addr(8'h0b);
        chk("hs_nack", 8'(ack), 8'h00);
        chk("hs_on", 8'(hs), 8'h01);
        addr(8'h54);
        chk("hs_addr", 8'(ack), 8'h01);
        chk("hs_kept", 8'(hs), 8'h01);
        m.stop_cond();
        chk("hs_off", 8'(hs), 8'h00);
        addr(8'hf0);
        chk("tenbit", 8'(ack), 8'h00);
        m.stop_cond();
    endtask : t_hs_tenbit
    task automatic t_read_collide();
        tx_byte = 8'hc2;
        addr(8'h55);
        chk("rd_dir", 8'(rd), 8'h01);
        m.recv_byte(b, 1'h1, 1'h0);
        chk("read", b, 8'hc2);
        m.recv_byte(b, 1'h0, 1'h0);
        chk("read_again", b, 8'hc2);
        m.stop_cond();
        tx_byte = 8'hff;
        col_seen = 1'h0;
        addr(8'h55);
        m.recv_byte(b, 1'h0, 1'h1);
        chk("collision", 8'(col_seen), 8'h01);
        chk("col_sel", 8'(addressed), 8'h00);
        m.stop_cond();
    endtask : t_read_collide

    initial begin
        reset = 1'h1;
        lsb = 1'h0;
        mid = 1'h1;
        msb = 1'h0;
        gce = 1'h0;
        busy = 1'h0;
        ack_ok = 1'h1;
        tx_byte = 8'h00;
        col_seen = 1'h0;
        repeat (6) @(negedge sys_clk);
        reset = 1'h0;
        repeat (8) @(negedge sys_clk);
        lsb = 1'h1;
        t_addr_sweep();
        t_write();
        t_data_nack();
        t_busy();
        t_gcall();
        t_hs_tenbit();
        t_read_collide();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        report_and_stop();
    end
endmodule : tb_pif_i2c_front
`default_nettype wire
